//--- src/sli_led_map.svh
// Timing constants for the status and CAN indicator block.
// Assumes a 250 MHz system clock; counts derive from times in ms.
`ifndef SLI_LED_MAP_SVH
`define SLI_LED_MAP_SVH

`define SLI_CLK_HZ         250000000
`define SLI_FLICKER_MS     50
`define SLI_BLINK_MS       200
`define SLI_FLASH_ON_MS    200
`define SLI_FLASH_OFF_MS   200
`define SLI_GROUP_GAP_MS   1000
`define SLI_MS_CYCLES      (`SLI_CLK_HZ / 1000)
`define SLI_FLICKER_CYC    (`SLI_FLICKER_MS * `SLI_MS_CYCLES)
`define SLI_BLINK_CYC      (`SLI_BLINK_MS * `SLI_MS_CYCLES)
`define SLI_FLASH_CYC      (`SLI_FLASH_ON_MS * `SLI_MS_CYCLES)
`define SLI_GAP_CYC        (`SLI_GROUP_GAP_MS * `SLI_MS_CYCLES)

`endif

//--- src/sli_pkg.sv
// Types shared by the indicator block.
// Assumes the map header supplies all numeric constants.
package sli_pkg;
   typedef enum logic [2:0] {
      SLI_NMT_INIT    = 3'h0,
      SLI_NMT_STOPPED = 3'h1,
      SLI_NMT_PREOP   = 3'h2,
      SLI_NMT_OPER    = 3'h3,
      SLI_NMT_DLOAD   = 3'h4,
      SLI_NMT_LSS     = 3'h5
   } sli_nmt_t;

   typedef enum logic [1:0] {
      SLI_PH_ON   = 2'b00,
      SLI_PH_OFF  = 2'b01,
      SLI_PH_GAP  = 2'b10
   } sli_phase_t;
endpackage

//--- src/sli_led.sv
// Front-panel indicator driver: status LED plus CAN run and error LEDs.
// Assumes condition inputs are synchronous to clk_i and held as levels.
`timescale 1ns/1ns
`include "sli_led_map.svh"

module sli_led
   import sli_pkg::*;
#(
   parameter int FLICKER_CYC = `SLI_FLICKER_CYC,
   parameter int BLINK_CYC   = `SLI_BLINK_CYC,
   parameter int FLASH_CYC   = `SLI_FLASH_CYC,
   parameter int GAP_CYC     = `SLI_GAP_CYC
) (
   // Clock and control
   input  wire logic            clk_i,
   input  wire logic            rst_i,
   input  wire logic            ce_i,
   // Controller core condition
   input  wire logic            init_busy_i,
   input  wire logic            init_fault_i,
   input  wire logic            fw_dload_i,
   input  wire logic            startup_done_i,
   // CAN node condition
   input  wire sli_pkg::sli_nmt_t nmt_state_i,
   input  wire logic            err_warn_i,
   input  wire logic            err_guard_i,
   input  wire logic            err_sync_i,
   input  wire logic            bus_off_i,
   // LED drives
   output logic                 stat_green_o,
   output logic                 stat_red_o,
   output logic                 can_green_o,
   output logic                 can_red_o
);
   import sli_pkg::*;

   // ----------------------------------------------------------------
   // Time bases
   // ----------------------------------------------------------------
   localparam int TW = 32;
   // Full-width counters so the one-second gap fits at the system rate;
   // narrower counters would save area but tie the block to slow clocks.

   logic [TW-1:0] flick_cnt;
   logic          flick;
   logic [TW-1:0] blink_cnt;
   logic          blink;

   function automatic logic tick(input logic [TW-1:0] cnt, input int lim);
      tick = (cnt == TW'(lim - 1));
   endfunction

   wire flick_tick = tick(flick_cnt, FLICKER_CYC);
   wire blink_tick = tick(blink_cnt, BLINK_CYC);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flick_cnt <= '0;
         flick     <= 1'b0;
         blink_cnt <= '0;
         blink     <= 1'b0;
      end else if (ce_i) begin
         flick_cnt <= flick_tick ? '0 : flick_cnt + TW'(1);
         blink_cnt <= blink_tick ? '0 : blink_cnt + TW'(1);
         if (flick_tick) flick <= ~flick;
         if (blink_tick) blink <= ~blink;
      end
   end

   // ----------------------------------------------------------------
   // Flash sequencer, one per flash-coded LED
   // ----------------------------------------------------------------
   // Each sequencer runs groups of n flashes then a long gap; n is latched
   // at the gap end, but the flashes are masked once the code falls to zero.
   logic [1:0]    g_want, r_want;
   logic [1:0]    g_num, r_num;
   logic [1:0]    g_idx, r_idx;
   sli_phase_t    g_ph, r_ph;
   logic [TW-1:0] g_cnt, r_cnt;

   function automatic logic [TW-1:0] ph_len(input sli_phase_t ph);
      ph_len = (ph == SLI_PH_GAP) ? TW'(GAP_CYC) : TW'(FLASH_CYC);
   endfunction

   wire g_end = (g_cnt == ph_len(g_ph) - TW'(1));
   wire r_end = (r_cnt == ph_len(r_ph) - TW'(1));

   assign g_want = (nmt_state_i == SLI_NMT_STOPPED) ? 2'h1 :
                   (nmt_state_i == SLI_NMT_DLOAD)   ? 2'h3 : 2'h0;

   assign r_want = err_sync_i  ? 2'h3 :
                   err_guard_i ? 2'h2 :
                   err_warn_i  ? 2'h1 : 2'h0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         g_ph  <= SLI_PH_GAP;
         g_cnt <= '0;
         g_idx <= '0;
         g_num <= '0;
      end else if (ce_i) begin
         g_cnt <= g_end ? '0 : g_cnt + TW'(1);
         if (g_end) begin
            unique case (g_ph)
               SLI_PH_ON: g_ph <= (g_idx + 2'h1 >= g_num) ? SLI_PH_GAP : SLI_PH_OFF;
               SLI_PH_OFF: begin
                  g_ph  <= SLI_PH_ON;
                  g_idx <= g_idx + 2'h1;
               end
               SLI_PH_GAP: begin
                  g_num <= g_want;
                  g_idx <= '0;
                  g_ph  <= (g_want != 2'h0) ? SLI_PH_ON : SLI_PH_GAP;
               end
               default: g_ph <= SLI_PH_GAP;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r_ph  <= SLI_PH_GAP;
         r_cnt <= '0;
         r_idx <= '0;
         r_num <= '0;
      end else if (ce_i) begin
         r_cnt <= r_end ? '0 : r_cnt + TW'(1);
         if (r_end) begin
            unique case (r_ph)
               SLI_PH_ON: r_ph <= (r_idx + 2'h1 >= r_num) ? SLI_PH_GAP : SLI_PH_OFF;
               SLI_PH_OFF: begin
                  r_ph  <= SLI_PH_ON;
                  r_idx <= r_idx + 2'h1;
               end
               SLI_PH_GAP: begin
                  r_num <= r_want;
                  r_idx <= '0;
                  r_ph  <= (r_want != 2'h0) ? SLI_PH_ON : SLI_PH_GAP;
               end
               default: r_ph <= SLI_PH_GAP;
            endcase
         end
      end
   end

   wire g_flash = (g_ph == SLI_PH_ON) && (g_want != 2'h0);
   wire r_flash = (r_ph == SLI_PH_ON) && (r_want != 2'h0);

   // ----------------------------------------------------------------
   // LED selection
   // ----------------------------------------------------------------
   logic next_stat_g, next_stat_r, next_can_g, next_can_r;
   wire  lss = (nmt_state_i == SLI_NMT_LSS);

   assign next_stat_r = init_fault_i ? blink : init_busy_i;
   assign next_stat_g = !init_fault_i && !init_busy_i && (fw_dload_i ? flick : 1'b1);

   assign next_can_g = !startup_done_i ? 1'b0 :
                       lss ? flick :
                       (nmt_state_i == SLI_NMT_PREOP) ? blink :
                       (nmt_state_i == SLI_NMT_OPER)  ? 1'b1 : g_flash;

   // Bus-off outranks the LSS flicker, so in that corner both CAN lamps
   // can be lit together; the solid red fault is the more urgent news.
   // bus-off solid red
   assign next_can_r = !startup_done_i ? 1'b0 :
                       bus_off_i ? 1'b1 :
                       lss ? !flick : r_flash;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_green_o <= 1'b0;
         stat_red_o   <= 1'b0;
         can_green_o  <= 1'b0;
         can_red_o    <= 1'b0;
      end else if (ce_i) begin
         stat_green_o <= next_stat_g;
         stat_red_o   <= next_stat_r;
         can_green_o  <= next_can_g;
         can_red_o    <= next_can_r;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_stat_solid_green: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !init_fault_i && !init_busy_i && !fw_dload_i |=> stat_green_o && !stat_red_o)
      else $error("status not solid green");
   a_stat_init_red: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !init_fault_i && init_busy_i |=> stat_red_o && !stat_green_o)
      else $error("status not red during init");
   a_stat_fault_flash: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && init_fault_i |=> !stat_green_o && (stat_red_o == $past(blink)))
      else $error("fault flash wrong");
   a_can_dark_pre: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !startup_done_i |=> !can_green_o && !can_red_o)
      else $error("CAN LEDs lit before startup");
   a_can_oper_green: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && startup_done_i && nmt_state_i == SLI_NMT_OPER |=> can_green_o)
      else $error("green not solid when operational");
   a_can_lss_alt: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && startup_done_i && lss && !bus_off_i |=> can_green_o != can_red_o)
      else $error("LSS flicker not alternating");
   a_can_busoff_red: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && startup_done_i && bus_off_i |=> can_red_o)
      else $error("red not solid in bus-off");
   a_can_red_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && startup_done_i && !bus_off_i && !lss && r_want == 2'h0 |=> !can_red_o)
      else $error("red lit without bus problem");
   a_red_flash_count: assert property (@(posedge clk_i) disable iff (rst_i)
      r_ph == SLI_PH_ON |-> r_idx < r_num)
      else $error("red flash count exceeded");
   a_flick_period: assert property (@(posedge clk_i) disable iff (rst_i)
      flick_cnt < TW'(FLICKER_CYC))
      else $error("flicker counter overran");

   // ----------------------------------------------------------------
   // Pattern, flash code and freeze assertions
   // ----------------------------------------------------------------
   a_stat_dload_flick: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !init_fault_i && !init_busy_i && fw_dload_i |=>
      !stat_red_o && (stat_green_o == $past(flick)))
      else $error("status not flickering during download");
   a_stat_one_colour: assert property (@(posedge clk_i) disable iff (rst_i)
      !(stat_green_o && stat_red_o))
      else $error("status lit in both colours");
   a_can_init_dark: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && startup_done_i && nmt_state_i == SLI_NMT_INIT |=> !can_green_o)
      else $error("green lit while node initializing");
   a_can_preop_blink: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && startup_done_i && nmt_state_i == SLI_NMT_PREOP |=>
      can_green_o == $past(blink))
      else $error("green not blinking when pre-operational");
   a_can_lss_red: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && startup_done_i && lss && !bus_off_i |=> can_red_o != $past(flick))
      else $error("red not flickering opposite green");

   // Group sizes are checked where a group starts, at the end of a gap
   a_green_one_flash: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && g_end && g_ph == SLI_PH_GAP && nmt_state_i == SLI_NMT_STOPPED |=>
      g_ph == SLI_PH_ON && g_num == 2'h1)
      else $error("stopped group is not one flash");
   a_green_three_flash: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && g_end && g_ph == SLI_PH_GAP && nmt_state_i == SLI_NMT_DLOAD |=>
      g_ph == SLI_PH_ON && g_num == 2'h3)
      else $error("download group is not three flashes");
   a_green_flash_count: assert property (@(posedge clk_i) disable iff (rst_i)
      g_ph == SLI_PH_ON |-> g_idx < g_num)
      else $error("green flash count exceeded");
   a_red_warn_code: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && r_end && r_ph == SLI_PH_GAP && err_warn_i && !err_guard_i && !err_sync_i |=>
      r_ph == SLI_PH_ON && r_num == 2'h1)
      else $error("warning group is not one flash");
   a_red_guard_code: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && r_end && r_ph == SLI_PH_GAP && err_guard_i && !err_sync_i |=>
      r_ph == SLI_PH_ON && r_num == 2'h2)
      else $error("guard group is not two flashes");
   a_red_sync_code: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && r_end && r_ph == SLI_PH_GAP && err_sync_i |=>
      r_ph == SLI_PH_ON && r_num == 2'h3)
      else $error("SYNC group is not three flashes");

   // Phase lengths bound the visible on, off and gap times
   a_flash_on_len: assert property (@(posedge clk_i) disable iff (rst_i)
      g_ph != SLI_PH_GAP |-> g_cnt < TW'(FLASH_CYC))
      else $error("flash phase overran");
   a_gap_len: assert property (@(posedge clk_i) disable iff (rst_i)
      r_ph == SLI_PH_GAP |-> r_cnt < TW'(GAP_CYC))
      else $error("group gap overran");
   a_blink_period: assert property (@(posedge clk_i) disable iff (rst_i)
      blink_cnt < TW'(BLINK_CYC))
      else $error("blink counter overran");

   // Enable low must freeze the lamps, the flicker time base and both flash counters
   a_freeze_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !ce_i |=> $stable(stat_green_o) && $stable(stat_red_o) && $stable(can_green_o) &&
      $stable(can_red_o) && $stable(flick_cnt) && $stable(g_cnt) && $stable(r_cnt))
      else $error("state moved while enable low");
endmodule

//--- bench/sli_view.sv
// Operator's view of the four lamps: tallies lit cycles while win_i is high.
// Assumes win_i changes away from the rising clock edge.
`timescale 1ns/1ns
module sli_view (
   // Clock and window
   input  wire logic        clk_i,
   input  wire logic        win_i,
   // Lamp drives
   input  wire logic [3:0]  led_i,
   // Tallies, valid while done_o is high
   output logic             done_o,
   output logic [15:0]      lit_o [4],
   output logic [15:0]      ov_o
);
   logic win_q = 1'b0;

   // Tallies clear only after the done cycle so the reader sees them whole
   always @(posedge clk_i) begin
      win_q  <= win_i;
      done_o <= win_q & ~win_i;
      for (int i = 0; i < 4; i++) begin
         if (!win_q && !win_i)
            lit_o[i] <= 16'h0000;
         else if (win_i)
            lit_o[i] <= lit_o[i] + 16'(led_i[i]);
      end
      if (!win_q && !win_i)
         ov_o <= 16'h0000;
      else if (win_i)
         ov_o <= ov_o + 16'(led_i[2] & led_i[3]);
   end
endmodule

//--- bench/sli_led_tb.sv
// Self-checking bench: drives condition sets, the viewer tallies lamp time.
// Assumes short pattern parameters so that whole periods fit in a window.
`timescale 1ns/1ns
module sli_led_tb;
   import sli_pkg::*;
   typedef struct {int l [4]; int ov;} sli_exp_t;
   localparam int FL = 4;
   localparam int BL = 8;
   localparam int FC = 8;
   localparam int GC = 20;
   logic        clk_i      = 1'b0;
   logic        rst_i      = 1'b1;
   logic [11:0] st         = 12'h001;
   logic        win        = 1'b0;
   logic [3:0]  led;
   logic        done;
   logic [15:0] lit [4];
   logic [15:0] ov;
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          cyc        = 0;
   sli_exp_t    q [$];
   logic [11:0] dir [10]   = '{12'h011, 12'h133, 12'h255, 12'h479, 12'h897,
                               12'h1B1, 12'h861, 12'h871, 12'h391, 12'h751};

   always #2 clk_i = ~clk_i;

   sli_led #(.FLICKER_CYC(FL), .BLINK_CYC(BL), .FLASH_CYC(FC), .GAP_CYC(GC)) uut (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(st[0]), .init_busy_i(st[1]),
      .init_fault_i(st[2]), .fw_dload_i(st[3]), .startup_done_i(st[4]),
      .nmt_state_i(sli_nmt_t'(st[7:5])), .err_warn_i(st[8]), .err_guard_i(st[9]),
      .err_sync_i(st[10]), .bus_off_i(st[11]), .stat_green_o(led[0]),
      .stat_red_o(led[1]), .can_green_o(led[2]), .can_red_o(led[3]));

   sli_view view (.clk_i(clk_i), .win_i(win), .led_i(led), .done_o(done),
      .lit_o(lit), .ov_o(ov));

   // Pattern codes: 0 dark, 1..3 flashes, 4 solid, 5 flicker, 6 blink
   function automatic int per(int c);
      return (c == 0 || c == 4) ? 1 : (c < 4) ? c * 2 * FC - FC + GC : (c == 5) ? 2 * FL : 2 * BL;
   endfunction
   function automatic int ont(int c);
      return (c == 4) ? 1 : (c < 4) ? c * FC : (c == 5) ? FL : BL;
   endfunction
   function automatic int gcd(int a, int b);
      return (b == 0) ? a : gcd(b, a % b);
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic test_done;
      $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Window spans whole periods of every lamp, so tallies are phase free
   // With frz set the enable drops after settling; use steady code sets only
   task automatic run(input logic [11:0] s, input bit frz);
      int c [4];
      int w;
      sli_exp_t e;
      logic [2:0] m;
      m = s[7:5];
      c[1] = s[2] ? 6 : s[1] ? 4 : 0;
      c[0] = (s[2] | s[1]) ? 0 : s[3] ? 5 : 4;
      c[2] = !s[4] ? 0 : m == 1 ? 1 : m == 2 ? 6 : m == 3 ? 4 : m == 4 ? 3 : m == 5 ? 5 : 0;
      c[3] = !s[4] ? 0 : s[11] ? 4 : m == 5 ? 5 : s[10] ? 3 : s[9] ? 2 : int'(s[8]);
      w = 1;
      foreach (c[i]) w = w / gcd(w, per(c[i])) * per(c[i]);
      if (frz) w = 64;
      foreach (c[i]) e.l[i] = w / per(c[i]) * ont(c[i]);
      e.ov = (c[2] == 5 && c[3] == 5) ? 0 : (c[2] == 4 && c[3] == 4) ? w : -1;
      st = s;
      repeat (150) @(negedge clk_i);
      // Frozen lamps keep their levels whatever the other inputs do
      if (frz) st = 12'($urandom()) & 12'hFFE;
      q.push_back(e);
      win = 1'b1;
      repeat (w) @(negedge clk_i);
      win = 1'b0;
      repeat (3) @(negedge clk_i);
      $display("test with conditions %h done", s);
   endtask

   always @(posedge done) begin
      sli_exp_t e;
      #1;
      e = q.pop_front();
      foreach (lit[i]) check(lit[i], 16'(e.l[i]));
      if (e.ov >= 0) check(ov, 16'(e.ov));
   end

   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         n_mismatch++;
         test_done;
      end
   end

   initial begin
      void'($urandom(32'hEFF0205E));
      repeat (16) @(negedge clk_i);
      check(16'(led), 16'h0000);
      rst_i = 1'b0;
      foreach (dir[i]) run(dir[i], 1'b0);
      run(12'h871, 1'b1);
      run(12'h013, 1'b1);
      repeat (10) run(12'($urandom()) | 12'h001, 1'b0);
      test_done;
   end
endmodule
